// ==== mmtb_defs.vh ====
// constants of the multi mode time base timer: offsets, fields, resets
`ifndef MMTB_DEFS_VH
`define MMTB_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MMTB_OFS_CTL1L   12'h000
`define MMTB_OFS_CTL1H   12'h004
`define MMTB_OFS_STATL   12'h008
`define MMTB_OFS_CNTL    12'h00c
`define MMTB_OFS_CNTH    12'h010
`define MMTB_OFS_PERL    12'h014
`define MMTB_OFS_PERH    12'h018

// ****************************************************************
// control one low fields
// ****************************************************************
`define MMTB_ENA_BIT     15
`define MMTB_CLK_HI      10
`define MMTB_CLK_LO      8
`define MMTB_WIDE_BIT    5
`define MMTB_CAP_BIT     4
`define MMTB_MODE_HI     3
`define MMTB_MODE_LO     0

// ****************************************************************
// control one high and status low fields
// ****************************************************************
`define MMTB_TRGEN_BIT   7
`define MMTB_SRC_HI      4
`define MMTB_SRC_LO      0
`define MMTB_TRGST_BIT   7
`define MMTB_TRIGGER_CLEAR_BIT   5

// ****************************************************************
// reset values and codes
// ****************************************************************
`define MMTB_CLK_SYS     3'h0
`define MMTB_MODE_TIMER  4'h0
`define MMTB_SRC_OFF     5'h00
`define MMTB_SRC_SELF    5'h1f
`define MMTB_PER_RST     16'hffff
`define MMTB_CNT_RST     16'h0000

`endif

// ==== mmtb_timer.v ====
// time base and general purpose timer of the multi output timer module
//
// What this block does
// R1: runs one major mode at a time only
// R2: one time base, one counter pair shared
// R3: clock source field picks one of eight
// R4: source 000 is system clock, reset default
// R5: every clock source synchronised to MCLK
// R6: timer mode when capture bit 0, mode 0000
// R7: width bit: dual 16-bit or one 32-bit
// R8: primary low timer makes sync out, takes sync
// R9: secondary high timer makes no sync output
// R10: dual mode high period match gives compare event
// R11: 32-bit: low overflow increments high counter
// R12: software sets width bit before loading counters
// R13: source field selects sync or trigger input
// R14: sync: selected input clears, counting restarts
// R15: software never picks 11111 for sync
// R16: trigger: held at zero until input fires
// R17: runs while triggered status stays set
// R18: trigger clear resets status and holds timer
// R19: software triggers only on system clock
// R20: enable bit turns module on, clear disables
// R21: capture select bit 4 picks capture mode
// R22: count up, zero and match at period
//
// Implementation choices: register access over APB and the placing of the registers.
`include "mmtb_defs.vh"

module mmtb_timer #(
    parameter CW = 16                   // width of each counter half
) (
    input  wire          MCLK,          // system clock, 40 MHz
    input  wire          RESET,         // synchronous, active high
    input  wire          PSEL,          // apb select
    input  wire          PENABLE,       // apb access phase
    input  wire          PWRITE,        // apb direction
    input  wire [11:0]   PADDR,         // apb byte address
    input  wire [31:0]   PWDATA,        // apb write data
    output wire [31:0]   PRDATA,        // apb read data
    output wire          PREADY,        // apb ready, always high
    output wire          PSLVERR,       // apb error on unmapped
    input  wire [7:1]    CLK_SRC,       // alternate clock sources
    input  wire [31:0]   SYNC_SRC,      // sync / trigger inputs
    output wire          SYNC_OUT,      // primary period pulse
    output wire          COMPARE_EVENT, // secondary / wide match
    output wire          TIMER_ACTIVE   // module counting in timer mode
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // one-hot pick from a vector by index; used for clock and sync
    function sel_bit;
        input [31:0] vec;
        input [4:0]  idx;
        sel_bit = vec[idx];
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    reg              ena_q;
    reg  [2:0]       clk_sel_q;
    reg              wide_q;
    reg              cap_sel_q;
    reg  [3:0]       mode_q;
    reg              trg_en_q;
    reg  [4:0]       src_sel_q;
    reg              trg_st_q;
    reg  [CW-1:0]    cnt_lo_q;
    reg  [CW-1:0]    cnt_hi_q;
    reg  [CW-1:0]    per_lo_q;
    reg  [CW-1:0]    per_hi_q;
    reg              sync_out_q;
    reg              cmp_evt_q;
    reg  [31:0]      rdata_q;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire             wr_en;
    wire             rd_en;
    wire             mapped;
    wire             hit_c1l;
    wire             hit_c1h;
    wire             hit_stl;
    wire             hit_cnl;
    wire             hit_cnh;
    wire             hit_prl;
    wire             hit_prh;

    assign hit_c1l = (PADDR == `MMTB_OFS_CTL1L);
    assign hit_c1h = (PADDR == `MMTB_OFS_CTL1H);
    assign hit_stl = (PADDR == `MMTB_OFS_STATL);
    assign hit_cnl = (PADDR == `MMTB_OFS_CNTL);
    assign hit_cnh = (PADDR == `MMTB_OFS_CNTH);
    assign hit_prl = (PADDR == `MMTB_OFS_PERL);
    assign hit_prh = (PADDR == `MMTB_OFS_PERH);
    assign mapped  = hit_c1l | hit_c1h | hit_stl | hit_cnl |
                     hit_cnh | hit_prl | hit_prh;

    // zero wait states: the access phase always completes at once
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign wr_en   = PSEL & PENABLE & PWRITE & mapped;
    assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
    assign PRDATA  = rdata_q;

    // ****************************************************************
    // clock source synchronisers
    // ****************************************************************
    reg  [7:1]       clk_s1_q;
    reg  [7:1]       clk_s2_q;
    reg  [7:1]       clk_s3_q;

    genvar g;
    generate
        for (g = 1; g < 8; g = g + 1) begin : g_csync
            // two flops, then a third for the edge detector
            always @(posedge MCLK) begin
                if (RESET) begin
                    clk_s1_q[g] <= 1'b0;
                    clk_s2_q[g] <= 1'b0;
                    clk_s3_q[g] <= 1'b0;
                end else begin
                    clk_s1_q[g] <= CLK_SRC[g];                  // R5
                    clk_s2_q[g] <= clk_s1_q[g];
                    clk_s3_q[g] <= clk_s2_q[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // time base clock generator
    // ****************************************************************
    wire [7:0]       rise;
    wire             tick;

    // slot 0 is the system clock itself, a tick every cycle
    assign rise = {clk_s2_q & ~clk_s3_q, 1'b1};                   // R4
    assign tick = sel_bit({24'h000000, rise}, {2'b00, clk_sel_q}); // R3

    // ****************************************************************
    // mode decode
    // ****************************************************************
    wire             run;
    wire             sel_in;
    wire             sync_clr;
    wire             trg_hold;
    wire             trg_fire;
    wire             trg_clr_wr;

    // capture and compare datapaths sit elsewhere; only timer counts
    assign run = ena_q & ~cap_sel_q                               // R20 R21
               & (mode_q == `MMTB_MODE_TIMER);                    // R1 R6
    assign TIMER_ACTIVE = run;

    // select 0 means off; 11111 loops back to our own sync out
    assign sel_in = (src_sel_q != `MMTB_SRC_OFF) &                // R13
                    sel_bit({sync_out_q, SYNC_SRC[30:0]}, src_sel_q);

    assign sync_clr   = run & ~trg_en_q & sel_in;                 // R14
    assign trg_fire   = run & trg_en_q & sel_in;                  // R16
    assign trg_clr_wr = wr_en & hit_stl & PWDATA[`MMTB_TRIGGER_CLEAR_BIT];
    assign trg_hold   = trg_en_q & ~trg_st_q;                     // R16 R18

    // ****************************************************************
    // triggered status
    // ****************************************************************
    // a trigger in the same cycle as a clear wins, so none is lost
    always @(posedge MCLK) begin
        if (RESET) begin
            trg_st_q <= 1'b0;
        end else if (trg_fire) begin
            trg_st_q <= 1'b1;                                     // R17
        end else if (trg_clr_wr | ~trg_en_q) begin
            trg_st_q <= 1'b0;                                     // R18
        end
    end

    // ****************************************************************
    // counter next state
    // ****************************************************************
    wire [2*CW-1:0]  cnt_w;
    wire [2*CW-1:0]  per_w;
    wire             lo_match;
    wire             hi_match;
    wire             w_match;
    wire             lo_zero;
    reg  [CW-1:0]    cnt_lo_d;
    reg  [CW-1:0]    cnt_hi_d;
    reg              sync_out_d;
    reg              cmp_evt_d;

    assign cnt_w    = {cnt_hi_q, cnt_lo_q};
    assign per_w    = {per_hi_q, per_lo_q};
    assign lo_match = (cnt_lo_q == per_lo_q);                     // R22
    assign hi_match = (cnt_hi_q == per_hi_q);
    assign w_match  = (cnt_w == per_w);
    // primary half is cleared and held by sync or missing trigger
    assign lo_zero  = sync_clr | (run & trg_hold);

    // both modes share the same two halves of the counter pair
    always @* begin
        cnt_lo_d   = cnt_lo_q;                                    // R2
        cnt_hi_d   = cnt_hi_q;
        sync_out_d = 1'b0;
        cmp_evt_d  = 1'b0;
        if (run & wide_q) begin
            if (lo_zero) begin
                cnt_lo_d = `MMTB_CNT_RST;
                cnt_hi_d = `MMTB_CNT_RST;
            end else if (tick & w_match) begin
                cnt_lo_d   = `MMTB_CNT_RST;
                cnt_hi_d   = `MMTB_CNT_RST;
                sync_out_d = 1'b1;
                cmp_evt_d  = 1'b1;
            end else if (tick) begin
                // low overflow carries into the high half
                {cnt_hi_d, cnt_lo_d} = cnt_w + {{(2*CW-1){1'b0}}, 1'b1}; // R11
            end
        end else if (run) begin
            if (lo_zero) begin
                cnt_lo_d = `MMTB_CNT_RST;                         // R8
            end else if (tick & lo_match) begin
                cnt_lo_d   = `MMTB_CNT_RST;
                sync_out_d = 1'b1;                                // R8
            end else if (tick) begin
                cnt_lo_d = cnt_lo_q + {{(CW-1){1'b0}}, 1'b1};     // R22
            end
            // secondary half ignores sync and trigger, drives no sync
            if (tick & hi_match) begin
                cnt_hi_d  = `MMTB_CNT_RST;                        // R9
                cmp_evt_d = 1'b1;                                 // R10
            end else if (tick) begin
                cnt_hi_d = cnt_hi_q + {{(CW-1){1'b0}}, 1'b1};     // R7
            end
        end
    end

    // ****************************************************************
    // counter and event flops
    // ****************************************************************
    // a bus write to a counter half overrides the count this cycle
    always @(posedge MCLK) begin
        if (RESET) begin
            cnt_lo_q   <= `MMTB_CNT_RST;
            cnt_hi_q   <= `MMTB_CNT_RST;
            sync_out_q <= 1'b0;
            cmp_evt_q  <= 1'b0;
        end else begin
            sync_out_q <= sync_out_d;
            cmp_evt_q  <= cmp_evt_d;
            cnt_lo_q   <= (wr_en & hit_cnl) ? PWDATA[CW-1:0] : cnt_lo_d;
            cnt_hi_q   <= (wr_en & hit_cnh) ? PWDATA[CW-1:0] : cnt_hi_d;
        end
    end

    assign SYNC_OUT      = sync_out_q;
    assign COMPARE_EVENT = cmp_evt_q;

    // ****************************************************************
    // control register writes
    // ****************************************************************
    // the width bit should be set before loading wide counts
    always @(posedge MCLK) begin
        if (RESET) begin
            ena_q     <= 1'b0;
            clk_sel_q <= `MMTB_CLK_SYS;                           // R4
            wide_q    <= 1'b0;
            cap_sel_q <= 1'b0;
            mode_q    <= `MMTB_MODE_TIMER;
            trg_en_q  <= 1'b0;
            src_sel_q <= `MMTB_SRC_OFF;
            per_lo_q  <= `MMTB_PER_RST;
            per_hi_q  <= `MMTB_PER_RST;
        end else if (wr_en) begin
            if (hit_c1l) begin
                ena_q     <= PWDATA[`MMTB_ENA_BIT];               // R20
                clk_sel_q <= PWDATA[`MMTB_CLK_HI:`MMTB_CLK_LO];   // R3
                wide_q    <= PWDATA[`MMTB_WIDE_BIT];              // R7
                cap_sel_q <= PWDATA[`MMTB_CAP_BIT];               // R21
                mode_q    <= PWDATA[`MMTB_MODE_HI:`MMTB_MODE_LO];
            end
            if (hit_c1h) begin
                trg_en_q  <= PWDATA[`MMTB_TRGEN_BIT];
                src_sel_q <= PWDATA[`MMTB_SRC_HI:`MMTB_SRC_LO];   // R13
            end
            if (hit_prl) begin
                per_lo_q <= PWDATA[CW-1:0];
            end
            if (hit_prh) begin
                per_hi_q <= PWDATA[CW-1:0];
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // captured in setup so data stands through the access phase
    always @(posedge MCLK) begin
        if (RESET) begin
            rdata_q <= 32'h00000000;
        end else if (rd_en) begin
            rdata_q <= 32'h00000000;
            if (hit_c1l) begin
                rdata_q[`MMTB_ENA_BIT]  <= ena_q;
                rdata_q[`MMTB_CLK_HI:`MMTB_CLK_LO] <= clk_sel_q;
                rdata_q[`MMTB_WIDE_BIT] <= wide_q;
                rdata_q[`MMTB_CAP_BIT]  <= cap_sel_q;
                rdata_q[`MMTB_MODE_HI:`MMTB_MODE_LO] <= mode_q;
            end
            if (hit_c1h) begin
                rdata_q[`MMTB_TRGEN_BIT] <= trg_en_q;
                rdata_q[`MMTB_SRC_HI:`MMTB_SRC_LO] <= src_sel_q;
            end
            if (hit_stl) begin
                // trigger clear is a strobe and always reads zero
                rdata_q[`MMTB_TRGST_BIT] <= trg_st_q;             // R17
            end
            if (hit_cnl) begin
                rdata_q[CW-1:0] <= cnt_lo_q;
            end
            if (hit_cnh) begin
                rdata_q[CW-1:0] <= cnt_hi_q;
            end
            if (hit_prl) begin
                rdata_q[CW-1:0] <= per_lo_q;
            end
            if (hit_prh) begin
                rdata_q[CW-1:0] <= per_hi_q;
            end
        end
    end

endmodule // mmtb_timer

// ==== mmtb_properties.sv ====
// port checker of the time base timer, bound to its top
`include "mmtb_defs.vh"

// ********
// checker
// ********
module mmtb_props (
    input logic        MCLK,          // clock
    input logic        RESET,         // sync reset
    input logic        PSEL,          // apb select
    input logic        PENABLE,       // apb access
    input logic        PWRITE,        // apb direction
    input logic [11:0] PADDR,         // apb address
    input logic [31:0] PWDATA,        // apb write data
    input logic [31:0] PRDATA,        // apb read data
    input logic        PREADY,        // apb ready
    input logic        PSLVERR,       // apb error
    input logic [31:0] SYNC_SRC,      // sync inputs
    input logic        SYNC_OUT,      // primary match
    input logic        COMPARE_EVENT, // compare event
    input logic        TIMER_ACTIVE   // timer mode on
);
    logic [4:0]  src_q;
    logic        trg_q;
    logic [15:0] perl_q;
    logic        act_q;
    wire wr = PSEL & PENABLE & PWRITE;
    wire mapped = PADDR <= `MMTB_OFS_PERH && PADDR[1:0] == 2'h0;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    // mirror of the fields the properties need, kept from bus writes
    always @(posedge MCLK) begin
        if (RESET) begin
            src_q  <= `MMTB_SRC_OFF;
            trg_q  <= 1'b0;
            perl_q <= `MMTB_PER_RST;
            act_q  <= 1'b0;
        end else if (wr && PADDR == `MMTB_OFS_CTL1H) begin
            src_q <= PWDATA[4:0];
            trg_q <= PWDATA[7];
        end else if (wr && PADDR == `MMTB_OFS_PERL) begin
            perl_q <= PWDATA[15:0];
        end else if (wr && PADDR == `MMTB_OFS_CTL1L) begin
            act_q <= PWDATA[15] & ~PWDATA[4] & (PWDATA[3:0] == 4'h0);
        end
    end

    zero_wait_a: assert property (PREADY)
        else $error("ready low");
    bad_addr_a: assert property (PSLVERR == (PSEL && PENABLE && !mapped))
        else $error("error flag wrong");
    upper_zero_a: assert property (PSEL && PENABLE && !PWRITE
        |-> PRDATA[31:16] == 16'h0000) else $error("upper read bits set");
    mode_decode_a: assert property (
        wr && PADDR == `MMTB_OFS_CTL1L |=> TIMER_ACTIVE == act_q)
        else $error("timer mode decode wrong");
    sync_idle_a: assert property (SYNC_OUT |-> $past(TIMER_ACTIVE))
        else $error("sync out while idle");
    cmp_idle_a: assert property (COMPARE_EVENT |-> $past(TIMER_ACTIVE))
        else $error("compare event while idle");
    reset_quiet_a: assert property ($past(RESET) |-> !SYNC_OUT
        && !COMPARE_EVENT && !TIMER_ACTIVE && PRDATA == 32'h0)
        else $error("outputs not quiet after reset");
    sync_hold_a: assert property (
        (!trg_q && src_q != 5'h00 && perl_q != 16'h0000
        && SYNC_SRC[src_q])[*2] |=> !SYNC_OUT)
        else $error("match while sync held");
    sync_one_a: assert property (SYNC_OUT && perl_q != 16'h0000
        |=> !SYNC_OUT) else $error("sync pulse too long");
endmodule // mmtb_props

bind mmtb_timer mmtb_props u_props (.MCLK, .RESET, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SYNC_SRC,
    .SYNC_OUT, .COMPARE_EVENT, .TIMER_ACTIVE);

// ==== mmtb_src_model.sv ====
// far side model: sync and trigger lines and alternate clocks

// ********
// source model
// ********
module mmtb_src_model (
    input  logic        MCLK,     // system clock
    output logic [31:0] SYNC_SRC, // sync and trigger lines
    output logic [7:1]  CLK_SRC   // alternate clocks
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        SYNC_SRC = 32'h0;
        CLK_SRC  = 7'h00;
    end
    // one line high for n cycles; line 31 is the own sync, never used
    task fire(input int idx, input int n);
        @(posedge MCLK);
        SYNC_SRC[idx] <= 1'b1;
        repeat (n) @(posedge MCLK);
        SYNC_SRC[idx] <= 1'b0;
    endtask
    // slow edges so the two stage synchroniser sees each one
    task ticks(input int idx, input int n);
        repeat (n) begin
            repeat (4) @(posedge MCLK);
            CLK_SRC[idx] <= 1'b1;
            repeat (4) @(posedge MCLK);
            CLK_SRC[idx] <= 1'b0;
        end
    endtask
endmodule // mmtb_src_model

// ==== multi_mode_time_base_timer_tb_top.sv ====
// self checking bench of the time base timer
`include "mmtb_defs.vh"

// ********
// bench
// ********
module multi_mode_time_base_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK = 1'b0;
    logic        RESET = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic [31:0] rd;
    logic        PREADY, PSLVERR, err, SYNC_OUT, COMPARE_EVENT, TIMER_ACTIVE;
    wire  [31:0] SYNC_SRC;
    wire  [7:1]  CLK_SRC;
    int          fails = 0;
    int          n_checks = 0;
    int          g;
    logic [31:0] ctl_vals [3] = '{32'h8010, 32'h8001, 32'h0000};

    // 40 MHz clock
    initial forever #12.5 MCLK = ~MCLK;

    mmtb_timer DUT (.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CLK_SRC, .SYNC_SRC,
        .SYNC_OUT, .COMPARE_EVENT, .TIMER_ACTIVE);
    mmtb_src_model u_src (.MCLK, .SYNC_SRC, .CLK_SRC);

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one apb transfer; held until ready is seen, bounded wait
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin
            fails++;
            report_and_stop();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    // cycles between two pulses of sync out or compare event
    task automatic gap(input bit cmp, output int g);
        int k;
        for (int j = 0; j < 2; j++) begin
            k = 0;
            do begin
                @(posedge MCLK);
                k++;
            end while ((cmp ? COMPARE_EVENT : SYNC_OUT) !== 1'b1 && k < 40);
            g = k;
        end
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        for (int i = 0; i < 7; i++)
            rdchk("reset value", 12'(i * 4), i >= 5 ? 32'hffff : 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped error", err, 1);
        check("unmapped data", rd, 0);
        apb(1'b1, `MMTB_OFS_PERL, 32'h4);
        apb(1'b1, `MMTB_OFS_PERH, 32'h2);
        apb(1'b1, `MMTB_OFS_CTL1L, 32'h8000);
        gap(1'b0, g);
        check("primary interval", 32'(g), 5);
        gap(1'b1, g);
        check("secondary interval", 32'(g), 3);
        check("timer active", TIMER_ACTIVE, 1);
        // capture select, other mode, disabled: none is timer mode
        foreach (ctl_vals[i]) begin
            apb(1'b1, `MMTB_OFS_CTL1L, ctl_vals[i]);
            @(posedge MCLK);
            check("mode decode", TIMER_ACTIVE, 0);
        end
        // wide: width bit set before counters are loaded
        apb(1'b1, `MMTB_OFS_CTL1L, 32'h0020);
        apb(1'b1, `MMTB_OFS_PERL, 32'hffff);
        apb(1'b1, `MMTB_OFS_PERH, 32'hffff);
        apb(1'b1, `MMTB_OFS_CNTL, 32'hfffe);
        apb(1'b1, `MMTB_OFS_CNTH, 32'h0);
        apb(1'b1, `MMTB_OFS_CTL1L, 32'h8020);
        repeat (3) @(posedge MCLK);
        rdchk("wide carry", `MMTB_OFS_CNTH, 1);
        apb(1'b1, `MMTB_OFS_CTL1L, 32'h8000);
        apb(1'b1, `MMTB_OFS_PERL, 32'h00ff);
        apb(1'b1, `MMTB_OFS_CTL1H, 32'h0003);
        fork
            u_src.fire(3, 8);
            begin
                repeat (4) @(posedge MCLK);
                rdchk("sync held", `MMTB_OFS_CNTL, 0);
            end
        join
        repeat (3) @(posedge MCLK);
        apb(1'b0, `MMTB_OFS_CNTL, 32'h0);
        check("sync restart", rd != 0, 1);
        // trigger only on the system clock
        apb(1'b1, `MMTB_OFS_CTL1H, 32'h0083);
        repeat (3) @(posedge MCLK);
        rdchk("trigger held", `MMTB_OFS_CNTL, 0);
        rdchk("not triggered", `MMTB_OFS_STATL, 0);
        u_src.fire(3, 1);
        repeat (3) @(posedge MCLK);
        rdchk("triggered", `MMTB_OFS_STATL, 32'h80);
        apb(1'b0, `MMTB_OFS_CNTL, 32'h0);
        check("trigger run", rd != 0, 1);
        apb(1'b1, `MMTB_OFS_STATL, 32'h20);
        rdchk("trigger cleared", `MMTB_OFS_STATL, 0);
        repeat (3) @(posedge MCLK);
        rdchk("held after clear", `MMTB_OFS_CNTL, 0);
        apb(1'b1, `MMTB_OFS_CTL1H, 32'h0);
        // every alternate clock source counts its own edges only
        for (int s = 1; s < 8; s++) begin
            apb(1'b1, `MMTB_OFS_CTL1L, 32'h8000 | (s << 8));
            apb(1'b1, `MMTB_OFS_CNTL, 32'h0);
            u_src.ticks(s, 2);
            repeat (4) @(posedge MCLK);
            rdchk("source ticks", `MMTB_OFS_CNTL, 2);
        end
        report_and_stop();
    end
endmodule // multi_mode_time_base_timer_tb_top
